// >>> verilog/drl_ref_ctrl.sv
// data input reference level control, driven by mode register writes
`timescale 1ns/1ps

// What this block does
// - range bit 0 picks upper range from 60%, 1 picks lower from 45%
// - six bit level field sets the reference level within the range
// - code zero is the range base, each code adds 0.65%, up to 0x32
// - range and level apply whatever the training enable bit says
// - new level settles within 150 ns; controller waits that long
module drl_ref_ctrl (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic        mr_wr,
    input  wire logic [7:0]  mr_data,
    output logic             ref_range_q,
    output logic [5:0]       ref_level_q,
    output logic             train_en_q,
    output logic [13:0]      ref_pct_q,
    output logic             ref_settling_q,
    output logic             ref_valid_q,
    output logic             code_reserved_q
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    drl_pkg::drl_state_e state_q;
    drl_pkg::drl_state_e state_d;
    logic [7:0]          cnt_q;
    logic [13:0]         calc_pct;
    logic                calc_rsvd;

    // ------------------------------------------------------------------
    // mode register image
    // ------------------------------------------------------------------
    // a write takes range, level and training bit together, in the same cycle
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ref_range_q <= drl_pkg::RANGE_RESET;
            ref_level_q <= drl_pkg::LEVEL_RESET;
            train_en_q  <= drl_pkg::TRAIN_RESET;
        end else if (mr_wr) begin
            // applied regardless of the training bit
            ref_range_q <= mr_data[drl_pkg::RANGE_BIT];
            ref_level_q <= mr_data[drl_pkg::LEVEL_LSB +:
                                   drl_pkg::LEVEL_WIDTH];
            train_en_q  <= mr_data[drl_pkg::TRAIN_BIT];
        end
        // no write: fields hold their value
    end

    // ------------------------------------------------------------------
    // level decode
    // ------------------------------------------------------------------
    drl_level_calc u_calc (
        .range_sel     (ref_range_q),
        .level_code    (ref_level_q),
        .level_pct     (calc_pct),
        .code_reserved (calc_rsvd)
    );

    // registered level, one cycle behind the image
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ref_pct_q       <= drl_pkg::BASE_UPPER_PCT;
            code_reserved_q <= 1'b0;
        end else begin
            // reserved codes keep last defined level
            if (!calc_rsvd) begin
                ref_pct_q <= calc_pct;
            end
            code_reserved_q <= calc_rsvd;
        end
    end

    // ------------------------------------------------------------------
    // settling timer
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            drl_pkg::DRL_ST_STABLE: begin
                if (mr_wr) begin
                    state_d = drl_pkg::DRL_ST_SETTLING;
                end
            end
            drl_pkg::DRL_ST_SETTLING: begin
                if (!mr_wr && cnt_q == drl_pkg::SETTLE_LAST) begin
                    state_d = drl_pkg::DRL_ST_STABLE;
                end
            end
            default: state_d = drl_pkg::DRL_ST_STABLE;
        endcase
    end

    // state register
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= drl_pkg::DRL_ST_STABLE;
        end else begin
            state_q <= state_d;
        end
    end

    // cycle counter restarts on every write
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 8'h00;
        end else if (mr_wr) begin
            cnt_q <= 8'h00;
        end else if (state_q == drl_pkg::DRL_ST_SETTLING) begin
            cnt_q <= 8'(cnt_q + 8'h01);
        end
    end

    // status flags registered from the next state
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ref_settling_q <= 1'b0;
            ref_valid_q    <= 1'b1;
        end else begin
            ref_settling_q <= (state_d == drl_pkg::DRL_ST_SETTLING);
            ref_valid_q    <= (state_d == drl_pkg::DRL_ST_STABLE);
        end
    end

endmodule

// >>> include/drl_pkg.sv
// constants and types for the data input reference level control block
package drl_pkg;

    // ------------------------------------------------------------------
    // command word layout (reference trim mode register image)
    // ------------------------------------------------------------------
    localparam int unsigned MR_WIDTH       = 8;
    localparam int unsigned LEVEL_LSB      = 0;
    localparam int unsigned LEVEL_WIDTH    = 6;
    localparam int unsigned RANGE_BIT      = 6;
    localparam int unsigned TRAIN_BIT      = 7;

    // ------------------------------------------------------------------
    // reset values and code limits
    // ------------------------------------------------------------------
    localparam logic [5:0]  LEVEL_RESET    = 6'h00;
    localparam logic        RANGE_RESET    = 1'b0;
    localparam logic        TRAIN_RESET    = 1'b0;
    localparam logic [5:0]  LEVEL_MAX_CODE = 6'h32;

    // ------------------------------------------------------------------
    // level arithmetic, hundredths of a percent of the output supply
    // ------------------------------------------------------------------
    localparam int unsigned PCT_WIDTH      = 14;
    localparam logic [13:0] BASE_UPPER_PCT = 14'h1770; // 60.00 %
    localparam logic [13:0] BASE_LOWER_PCT = 14'h1194; // 45.00 %
    localparam logic [13:0] STEP_PCT       = 14'h0041; // 0.65 %

    // ------------------------------------------------------------------
    // settling time
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS  = 5000;
    localparam int unsigned SETTLE_NS      = 150;
    // longest time: round down, at least one cycle
    localparam int unsigned SETTLE_CYC_RAW = (SETTLE_NS * 1000) / CLK_PERIOD_PS;
    localparam int unsigned SETTLE_CYC     = (SETTLE_CYC_RAW < 1) ? 1
                                                                  : SETTLE_CYC_RAW;
    localparam int unsigned CNT_WIDTH      = 8;
    localparam logic [7:0]  SETTLE_LAST    = 8'(SETTLE_CYC - 1);

    // ------------------------------------------------------------------
    // settling state machine
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        DRL_ST_STABLE   = 2'b01,
        DRL_ST_SETTLING = 2'b10
    } drl_state_e;

endpackage

// >>> verilog/drl_level_calc.sv
// level code to reference percentage converter
`timescale 1ns/1ps

// turns range bit and level code into hundredths of a percent
module drl_level_calc (
    input  wire logic        range_sel,
    input  wire logic [5:0]  level_code,
    output logic      [13:0] level_pct,
    output logic             code_reserved
);

    logic [13:0] base_pct;
    logic [13:0] step_sum;

    // ------------------------------------------------------------------
    // base plus code times step
    // ------------------------------------------------------------------
    always_comb begin
        base_pct = range_sel ? drl_pkg::BASE_LOWER_PCT
                             : drl_pkg::BASE_UPPER_PCT;
        step_sum = 14'(level_code * drl_pkg::STEP_PCT);
        level_pct = 14'(base_pct + step_sum);
        code_reserved = (level_code > drl_pkg::LEVEL_MAX_CODE);
    end

endmodule

// >>> bench/drl_ref_ctrl_monitor.sv
// port checker for the reference level control block
`timescale 1ns/1ps
module drl_ref_ctrl_mon (
    input wire logic        clk_sys,
    input wire logic        arst_n,
    input wire logic        mr_wr,
    input wire logic [7:0]  mr_data,
    input wire logic        ref_range_q,
    input wire logic [5:0]  ref_level_q,
    input wire logic        train_en_q,
    input wire logic [13:0] ref_pct_q,
    input wire logic        ref_settling_q,
    input wire logic        ref_valid_q,
    input wire logic        code_reserved_q
);
    logic [7:0]  idle_q;
    logic [13:0] exp_pct;
    logic        rsv;
    // ----------------------------------------
    // expected level and idle cycle counter
    // ----------------------------------------
    assign rsv = mr_data[5:0] > 6'h32;
    assign exp_pct = (mr_data[6] ? 14'h1194 : 14'h1770) + 14'h0041 * mr_data[5:0];
    // counts cycles since the last write, stops at the top
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            idle_q <= 8'hff;
        end else if (mr_wr) begin
            idle_q <= 8'h00;
        end else if (idle_q != 8'hff) begin
            idle_q <= idle_q + 8'h01;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    fields_a: assert property (mr_wr |=>
        {train_en_q, ref_range_q, ref_level_q} == $past(mr_data))
        else $error("stored fields differ from write");
    settle_a: assert property (mr_wr |=> ref_settling_q && !ref_valid_q)
        else $error("settling not raised by write");
    count_a: assert property (ref_settling_q == (idle_q < 8'd30))
        else $error("settling time wrong");
    valid_a: assert property (ref_valid_q != ref_settling_q)
        else $error("valid not inverse of settling");
    hold_a: assert property (!mr_wr |=>
        $stable({train_en_q, ref_range_q, ref_level_q}))
        else $error("fields changed without write");
    pct_a: assert property (mr_wr && !rsv |-> ##2
        ref_pct_q == $past(exp_pct, 2)) else $error("level value wrong");
    flag_a: assert property (mr_wr |-> ##2
        code_reserved_q == $past(rsv, 2)) else $error("reserved flag wrong");
    keep_a: assert property (mr_wr && rsv |-> ##2 $stable(ref_pct_q))
        else $error("reserved code changed level");
endmodule
bind drl_ref_ctrl drl_ref_ctrl_mon mon_u (.clk_sys(clk_sys), .arst_n(arst_n),
    .mr_wr(mr_wr), .mr_data(mr_data), .ref_range_q(ref_range_q),
    .ref_level_q(ref_level_q), .train_en_q(train_en_q), .ref_pct_q(ref_pct_q),
    .ref_settling_q(ref_settling_q), .ref_valid_q(ref_valid_q),
    .code_reserved_q(code_reserved_q));

// >>> bench/drl_ctrl_model.sv
// memory controller model issuing reference trim writes
`timescale 1ns/1ps
module drl_ctrl_model (
    input  wire logic clk_sys,
    output logic      mr_wr,
    output logic [7:0] mr_data
);
    initial begin
        mr_wr = 1'b0;
        mr_data = 8'h00;
    end
    // back to back writes, one word per cycle; codes come from caller
    task automatic wr(input logic [6:0] q[$], input logic tr);
        @(posedge clk_sys);
        foreach (q[i]) begin
            mr_wr <= 1'b1;
            mr_data <= {tr, q[i]};
            @(posedge clk_sys);
        end
        mr_wr <= 1'b0;
        mr_data <= ~mr_data; // released bus shows no stale word
    endtask
endmodule

// >>> bench/drl_ref_ctrl_tb.sv
// testbench for the reference level control block
`timescale 1ns/1ps
module drl_ref_ctrl_tb;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic mr_wr, ref_range_q, train_en_q, ref_settling_q;
    logic ref_valid_q, code_reserved_q;
    logic [7:0] mr_data;
    logic [5:0] ref_level_q;
    logic [13:0] ref_pct_q;
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;
    always #2.5 clk_sys = ~clk_sys;
    drl_ctrl_model model_u (.clk_sys(clk_sys), .mr_wr(mr_wr), .mr_data(mr_data));
    drl_ref_ctrl dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .mr_wr(mr_wr),
        .mr_data(mr_data), .ref_range_q(ref_range_q), .ref_level_q(ref_level_q),
        .train_en_q(train_en_q), .ref_pct_q(ref_pct_q),
        .ref_settling_q(ref_settling_q), .ref_valid_q(ref_valid_q),
        .code_reserved_q(code_reserved_q));
    task summarize;
        if (n_fail == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task chk(input logic ok, input string m);
        n_tests++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    // cuts a hung run short
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            summarize;
        end
    end
    task t_reset;
        @(posedge clk_sys);
        arst_n <= 1'b0;
        repeat (10) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(negedge clk_sys);
        chk({ref_range_q, ref_level_q, train_en_q, ref_pct_q} === 22'h001770, "reset fields");
        chk({ref_settling_q, ref_valid_q, code_reserved_q} === 3'b010, "reset flags");
    endtask
    // one write, then follow settling to its exact end
    task t_level(input logic r, input logic [5:0] c);
        model_u.wr('{{r, c}}, 1'b1);
        @(negedge clk_sys);
        chk({ref_range_q, ref_level_q, ref_settling_q} === {r, c, 1'b1}, "level stored");
        repeat (29) @(negedge clk_sys);
        chk(ref_settling_q === 1'b1, "settled early");
        @(negedge clk_sys);
        chk(ref_valid_q === 1'b1, "not settled in time");
        chk(ref_pct_q === (r ? 14'h1194 : 14'h1770) + 14'h0041 * c, "level value");
    endtask
    task t_rsv;
        t_level(1'b1, 6'h10);
        model_u.wr('{7'h73, 7'h7f}, 1'b1);
        repeat (2) @(negedge clk_sys);
        chk({code_reserved_q, ref_level_q, ref_pct_q} === {7'h7f, 14'h15a4}, "reserved code");
        t_level(1'b0, 6'h32);
        chk(code_reserved_q === 1'b0, "reserved flag stuck");
    endtask
    task t_train;
        model_u.wr('{7'h45}, 1'b0);
        @(negedge clk_sys);
        chk({train_en_q, ref_range_q, ref_level_q} === 8'h45, "update without enable");
        t_level(1'b0, 6'h01);
        chk(train_en_q === 1'b1, "enable not stored");
    endtask
    initial begin
        t_reset;
        for (int r = 0; r < 2; r++) begin
            for (int c = 0; c <= 50; c++) begin
                t_level(r[0], c[5:0]);
            end
        end
        t_rsv;
        t_train;
        t_reset;
        t_level(1'b1, 6'h00);
        summarize;
    end
endmodule
